// ===== verilog/cfg_sel_pkg.sv
// Package: types, tables and constants for the pin/register configuration selector
package cfg_sel_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Three-level pin encoding
    typedef logic [1:0] tri_lvl_t;                    // One three-level pin as seen by the pad
    localparam tri_lvl_t LVL_LOW  = 2'h0;             // Driven low
    localparam tri_lvl_t LVL_MID  = 2'h1;             // Driven to middle voltage
    localparam tri_lvl_t LVL_HIGH = 2'h2;             // Driven high
    localparam tri_lvl_t LVL_OPEN = 2'h3;             // Left open, bias network gives middle

    // Pair of three-level pins forming one control group
    typedef struct packed {
        tri_lvl_t hi;                                 // Upper pin of the pair
        tri_lvl_t lo;                                 // Lower pin of the pair
    } pin_pair_t;

    localparam int        NUM_LVL      = 3;           // Levels per pin
    localparam int        NUM_PRESET   = 9;           // Decoded codes per pin pair
    localparam int        NUM_BANK     = 4;           // Output banks A..D
    localparam int        NUM_GRP      = 5;           // PLL group plus one per bank
    localparam int        IDX_W        = 4;           // Width of a decoded pair index
    localparam int        GRP_PLL      = 0;           // Group number of the PLL controls

    ////////////////////////////////////////////////////////////////////////////////
    // Configuration carriers
    typedef struct packed {
        logic [5:0] prescaler_ratio;                  // Input prescaler divide value
        logic       input_doubler;                    // 1 doubles the input, 0 passes it
        logic [8:0] fb_div;                           // PLL feedback divider value
    } pll_cfg_t;

    typedef enum logic [1:0] {
        OT_LVDS   = 2'b00,                            // Differential LVDS swing
        OT_LVPECL = 2'b01,                            // Differential LVPECL swing
        OT_PDOWN  = 2'b10                             // Bank powered down
    } out_type_t;

    typedef struct packed {
        logic [7:0] div;                              // Integer output divide ratio
        out_type_t  otype;                            // Output driver type
    } bank_cfg_t;

    // Control select bits, one per function group
    typedef struct packed {
        logic bank_d_ctl_sel;                         // Bank D from registers when set
        logic bank_c_ctl_sel;                         // Bank C from registers when set
        logic bank_b_ctl_sel;                         // Bank B from registers when set
        logic bank_a_ctl_sel;                         // Bank A from registers when set
        logic pll_group_ctl_sel;                      // Prescaler/doubler/feedback from registers
    } ctl_sel_t;

    // Whole register image written by the serial host
    typedef struct packed {
        ctl_sel_t                   ctl_sel;          // Per-group source selects
        pll_cfg_t                   pll;              // PLL register fields
        bank_cfg_t [NUM_BANK-1:0]   bank;             // Bank register fields
    } reg_image_t;

    // Preset table entry selected by the PLL pin pair
    typedef struct packed {
        logic [31:0] fin_khz;                         // Implied input frequency in kHz
        logic [31:0] fvco_khz;                        // Implied VCO frequency in kHz
        pll_cfg_t    cfg;                             // Divider settings for the preset
    } preset_t;

    ////////////////////////////////////////////////////////////////////////////////
    // Reset defaults of the register image
    localparam ctl_sel_t  CTL_SEL_RST  = '0;          // All groups under pin control
    localparam pll_cfg_t  PLL_CFG_RST  = '{6'h01, 1'b1, 9'h019};
    localparam bank_cfg_t BANK_CFG_RST = '{8'h10, OT_LVDS};

    // Preset index = hi level * 3 + lo level, levels low=0 mid=1 high=2
    localparam preset_t PRESET_TAB [NUM_PRESET] = '{
        '{32'h0000_C350, 32'h0026_25A0, '{6'h01, 1'b1, 9'h019}},  // Low/Low 50 MHz
        '{32'h0000_61A8, 32'h0026_25A0, '{6'h01, 1'b1, 9'h032}},  // Low/Mid 25 MHz
        '{32'h0001_86A0, 32'h0026_25A0, '{6'h01, 1'b0, 9'h019}},  // Low/High 100 MHz
        '{32'h0002_625A, 32'h0026_25A0, '{6'h01, 1'b0, 9'h010}},  // Mid/Low 156.25 MHz
        '{32'h0001_E848, 32'h0026_25A0, '{6'h01, 1'b0, 9'h014}},  // Mid/Mid 125 MHz
        '{32'h0004_C4B4, 32'h0026_25A0, '{6'h02, 1'b0, 9'h010}},  // Mid/High 312.5 MHz
        '{32'h0000_7A12, 32'h0026_25A0, '{6'h01, 1'b1, 9'h028}},  // High/Low 31.25 MHz
        '{32'h0000_9600, 32'h0025_8000, '{6'h01, 1'b1, 9'h020}},  // High/Mid 38.4 MHz
        '{32'h0000_97E0, 32'h0025_F800, '{6'h01, 1'b1, 9'h020}}   // High/High 38.88 MHz
    };

    // Bank pin decode: divide ratio and driver type per pair index
    localparam logic [7:0] BANK_PIN_DIV [NUM_PRESET] = '{
        8'h01, 8'h02, 8'h04, 8'h05, 8'h08, 8'h0A, 8'h10, 8'h14, 8'h19
    };
    localparam out_type_t BANK_PIN_TYPE [NUM_PRESET] = '{
        OT_LVDS, OT_LVDS, OT_LVDS, OT_LVPECL, OT_LVPECL, OT_LVPECL,
        OT_LVDS, OT_LVPECL, OT_PDOWN
    };

endpackage

// ===== verilog/tri_pair_decode.sv
// Module: decodes a pair of three-level control pins into a 0..8 index
`timescale 1ns/100ps
module tri_pair_decode
    import cfg_sel_pkg::*;
(
    // Pin pair
    input  cfg_sel_pkg::pin_pair_t          pins,
    // Decoded index
    output logic [cfg_sel_pkg::IDX_W-1:0]   idx
);

    ////////////////////////////////////////////////////////////////////////////////
    // Open pins resolve to middle, like the weak bias network does
    function automatic logic [IDX_W-1:0] lvl_val(input tri_lvl_t l);
        logic [IDX_W-1:0] v;
        v = '0;
        unique case (l)
            LVL_LOW:  v = IDX_W'(0);
            LVL_MID:  v = IDX_W'(1);
            LVL_OPEN: v = IDX_W'(1);
            LVL_HIGH: v = IDX_W'(2);
        endcase
        return v;
    endfunction

    // Upper pin weighs three, lower pin one
    always_comb begin
        idx = IDX_W'(lvl_val(pins.hi) * IDX_W'(NUM_LVL) + lvl_val(pins.lo));
    end

endmodule // tri_pair_decode

// ===== verilog/pin_register_config_select.sv
// Module: chooses pin or register control per function, presets, sync and lock
//
// Summary of operation
// - Reset puts every function under pin control
// - Host selects register control per function independently
// - Each function uses pins or registers, never both
// - Register values revert to defaults at power-up
// - Five selects: PLL group and four banks
// - Dividers sync at power-up, later only on command
// - Divider change plus sync command loads and syncs
// - Reference select pin picks crystal or clock input
// - Select low uses crystal, high uses clock
// - PLL pins decode nine presets with fin/fvco
// - Presets identical for either reference source
// - Open three-level pin decodes as middle
// - Register control takes prescaler, doubler, feedback from registers
// - Lock status reported continuously on lock pin
// - Lock pin high when locked, low otherwise
// - Four banks, each bank one frequency
`timescale 1ns/100ps
module pin_register_config_select
    import cfg_sel_pkg::*;
(
    // Clock and reset
    input  wire logic                               clk_sys,
    input  wire logic                               rst_n,
    // Register writes from the serial port
    input  wire logic                               cfg_wr_en,
    input  wire logic [cfg_sel_pkg::NUM_GRP-1:0]    cfg_wr_mask,
    input  wire cfg_sel_pkg::reg_image_t            cfg_wr_data,
    input  wire logic                               init_clk_cmd,
    // Control pins
    input  wire cfg_sel_pkg::pin_pair_t             pll_preset_pins,
    input  wire cfg_sel_pkg::pin_pair_t             bank_a_pins,
    input  wire cfg_sel_pkg::pin_pair_t             bank_b_pins,
    input  wire cfg_sel_pkg::pin_pair_t             bank_c_pins,
    input  wire cfg_sel_pkg::pin_pair_t             bank_d_pins,
    input  wire logic                               ref_sel,
    input  wire logic [31:0]                        ref_freq_khz,
    // Analog PLL status
    input  wire logic                               pll_locked,
    // Register read-back
    output cfg_sel_pkg::reg_image_t                 cfg_rd_data,
    // PLL setting in force
    output logic                                    ref_use_clk,
    output cfg_sel_pkg::pll_cfg_t                   pll_eff,
    output logic [31:0]                             fpfd_khz,
    output logic [31:0]                             fvco_khz,
    // Banks
    output cfg_sel_pkg::bank_cfg_t [cfg_sel_pkg::NUM_BANK-1:0] bank_eff,
    output logic [cfg_sel_pkg::NUM_BANK-1:0]        bank_tick,
    output logic                                    div_sync,
    // Lock indicator pin
    output logic                                    lock
);

    ////////////////////////////////////////////////////////////////////////////////
    // Pin decode for all five groups
    pin_pair_t            grp_pins [NUM_GRP];       // Pin pairs, group 0 is the PLL
    logic [IDX_W-1:0]     grp_idx  [NUM_GRP];       // Decoded 0..8 per group

    always_comb begin
        grp_pins[0] = pll_preset_pins;
        grp_pins[1] = bank_a_pins;
        grp_pins[2] = bank_b_pins;
        grp_pins[3] = bank_c_pins;
        grp_pins[4] = bank_d_pins;
    end

    // One decoder per group
    generate
        for (genvar g = 0; g < NUM_GRP; g++) begin : g_dec
            tri_pair_decode u_dec (
                .pins (grp_pins[g]),
                .idx  (grp_idx[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // Register image, lost at power-down because reset restores defaults
    reg_image_t           img_r;                    // Held register fields
    reg_image_t           img_nxt;                  // Next register fields
    logic [NUM_GRP-1:0]   sel_vec;                  // Selects, bit 0 = PLL group

    // Masked write: each group changes alone
    always_comb begin
        img_nxt = img_r;
        if (cfg_wr_en) begin
            if (cfg_wr_mask[GRP_PLL]) begin
                img_nxt.ctl_sel.pll_group_ctl_sel = cfg_wr_data.ctl_sel.pll_group_ctl_sel;
                img_nxt.pll = cfg_wr_data.pll;
            end
            for (int b = 0; b < NUM_BANK; b++) begin
                if (cfg_wr_mask[b+1]) begin
                    img_nxt.bank[b] = cfg_wr_data.bank[b];
                end
            end
            // Bank selects sit in the struct above the PLL select
            if (cfg_wr_mask[1]) img_nxt.ctl_sel.bank_a_ctl_sel = cfg_wr_data.ctl_sel.bank_a_ctl_sel;
            if (cfg_wr_mask[2]) img_nxt.ctl_sel.bank_b_ctl_sel = cfg_wr_data.ctl_sel.bank_b_ctl_sel;
            if (cfg_wr_mask[3]) img_nxt.ctl_sel.bank_c_ctl_sel = cfg_wr_data.ctl_sel.bank_c_ctl_sel;
            if (cfg_wr_mask[4]) img_nxt.ctl_sel.bank_d_ctl_sel = cfg_wr_data.ctl_sel.bank_d_ctl_sel;
        end
    end

    // Defaults give pin control everywhere
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            img_r.ctl_sel <= CTL_SEL_RST;
            img_r.pll     <= PLL_CFG_RST;
            img_r.bank    <= {NUM_BANK{BANK_CFG_RST}};
        end else begin
            img_r <= img_nxt;
        end
    end

    assign sel_vec     = img_r.ctl_sel;
    assign cfg_rd_data = img_r;

    ////////////////////////////////////////////////////////////////////////////////
    // Sync sequencer: one sync after reset, then only on command
    typedef enum logic [1:0] {
        ST_PWRUP = 2'b00,                           // First cycle after reset
        ST_RUN   = 2'b01,                           // Dividers free running
        ST_SYNC  = 2'b10                            // Load and restart dividers
    } sync_st_t;

    sync_st_t             st_r;                     // Current state
    sync_st_t             st_nxt;                   // Next state

    always_comb begin
        st_nxt = st_r;
        unique case (st_r)
            ST_PWRUP: st_nxt = ST_SYNC;
            ST_RUN:   st_nxt = init_clk_cmd ? ST_SYNC : ST_RUN;
            ST_SYNC:  st_nxt = init_clk_cmd ? ST_SYNC : ST_RUN;
            default:  st_nxt = ST_PWRUP;            // Illegal code recovers via a fresh sync
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= ST_PWRUP;
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // PLL group source mux and frequency plan
    pll_cfg_t             pll_nxt;                  // Chosen PLL setting
    logic [31:0]          fin_sel;                  // Input frequency assumed
    logic [31:0]          fpfd_nxt;                 // Phase detector frequency
    logic [31:0]          fvco_nxt;                 // VCO frequency
    logic [5:0]           ps_safe;                  // Prescaler, zero treated as one

    // Preset lookup ignores ref_sel so both sources behave alike
    always_comb begin
        if (sel_vec[GRP_PLL]) begin
            pll_nxt = img_r.pll;
            fin_sel = ref_freq_khz;
        end else begin
            pll_nxt = PRESET_TAB[grp_idx[GRP_PLL]].cfg;
            fin_sel = PRESET_TAB[grp_idx[GRP_PLL]].fin_khz;
        end
        ps_safe  = (pll_nxt.prescaler_ratio == 6'h00) ? 6'h01 : pll_nxt.prescaler_ratio;
        // Divide after doubling to keep the half-kHz precision
        fpfd_nxt = ((pll_nxt.input_doubler ? {fin_sel[30:0], 1'b0} : fin_sel)
                    / {26'h0, ps_safe});
        fvco_nxt = 32'(fpfd_nxt * {23'h0, pll_nxt.fb_div});
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pll_eff     <= PLL_CFG_RST;
            fpfd_khz    <= '0;
            fvco_khz    <= '0;
            ref_use_clk <= 1'b0;
        end else begin
            pll_eff     <= pll_nxt;
            fpfd_khz    <= fpfd_nxt;
            fvco_khz    <= fvco_nxt;
            ref_use_clk <= ref_sel;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Bank source mux, divider loading and divider counters
    bank_cfg_t [NUM_BANK-1:0] bank_nxt;             // Next active bank setting
    logic [7:0]           cnt_r   [NUM_BANK];       // Divider counters
    logic [7:0]           cnt_nxt [NUM_BANK];       // Next counter values
    logic [NUM_BANK-1:0]  tick_nxt;                 // Next bank ticks
    logic                 sync_now;                 // Load and restart this cycle

    assign sync_now = (st_r == ST_SYNC);

    generate
        for (genvar b = 0; b < NUM_BANK; b++) begin : g_bank
            logic [7:0] div_lim;                    // Ratio, zero treated as one

            // Pins act at once; register divider only at a sync, register driver type at once
            always_comb begin
                bank_nxt[b] = bank_eff[b];
                if (!sel_vec[b+1]) begin
                    bank_nxt[b].div   = BANK_PIN_DIV[grp_idx[b+1]];
                    bank_nxt[b].otype = BANK_PIN_TYPE[grp_idx[b+1]];
                end else if (sync_now) begin
                    bank_nxt[b] = img_r.bank[b];
                end else begin
                    bank_nxt[b].otype = img_r.bank[b].otype;
                end
                div_lim = (bank_eff[b].div == 8'h00) ? 8'h01 : bank_eff[b].div;
                // Whole bank shares one counter, so one frequency
                if (sync_now || cnt_r[b] >= div_lim - 8'h01) begin
                    cnt_nxt[b] = 8'h00;
                end else begin
                    cnt_nxt[b] = cnt_r[b] + 8'h01;
                end
                tick_nxt[b] = !sync_now && (cnt_r[b] >= div_lim - 8'h01)
                              && (bank_eff[b].otype != OT_PDOWN);
            end

            always_ff @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    bank_eff[b]  <= BANK_CFG_RST;
                    cnt_r[b]     <= 8'h00;
                    bank_tick[b] <= 1'b0;
                end else begin
                    bank_eff[b]  <= bank_nxt[b];
                    cnt_r[b]     <= cnt_nxt[b];
                    bank_tick[b] <= tick_nxt[b];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // Sync pulse and lock pin; lock follows the analog detector with one flop
    logic                 lock_nxt;                 // Next lock pin level
    logic                 sync_nxt;                 // Next sync pulse

    always_comb begin
        lock_nxt = pll_locked;
        sync_nxt = sync_now;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            lock     <= 1'b0;
            div_sync <= 1'b0;
        end else begin
            lock     <= lock_nxt;
            div_sync <= sync_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    sequence s_cmd;
        init_clk_cmd && st_r == ST_RUN;
    endsequence
    sequence s_sync_out;
        ##1 sync_now ##1 div_sync;
    endsequence

    a_cmd_sync_pulse: assert property (s_cmd |-> s_sync_out)
        else $error("sync command did not produce a divider sync");
    a_sync_only_cmd: assert property (
        $rose(sync_now) && $past(st_r) == ST_RUN |-> $past(init_clk_cmd))
        else $error("divider sync without command");
    a_reg_bank_load: assert property (
        sync_now && sel_vec[1] |=> bank_eff[0].div == $past(img_r.bank[0].div))
        else $error("bank A divider not loaded at sync");
    a_reg_bank_hold: assert property (
        sel_vec[1] && $past(sel_vec[1]) && !sync_now && !$past(sync_now)
        |=> $stable(bank_eff[0].div))
        else $error("register divider changed without sync");
    a_pin_bank_mux: assert property (
        rst_n && !sel_vec[2] |=> bank_eff[1].div == BANK_PIN_DIV[$past(grp_idx[2])])
        else $error("bank B not following its pins");
    a_pll_reg_mux: assert property (
        sel_vec[GRP_PLL] |=> pll_eff == $past(img_r.pll))
        else $error("PLL group not taken from registers");
    a_preset_mux: assert property (
        rst_n && !sel_vec[GRP_PLL] && pll_preset_pins == pin_pair_t'{LVL_HIGH, LVL_HIGH}
        |=> fvco_khz == PRESET_TAB[NUM_PRESET-1].fvco_khz)
        else $error("high/high preset wrong");
    a_open_is_mid: assert property (
        rst_n && !sel_vec[GRP_PLL] && pll_preset_pins == pin_pair_t'{LVL_OPEN, LVL_OPEN}
        |=> pll_eff == PRESET_TAB[4].cfg)
        else $error("open pins not decoded as middle");
    a_lock_follow: assert property (rst_n && pll_locked |=> lock)
        else $error("lock pin low while locked");
    a_unlock_follow: assert property (!pll_locked |=> !lock)
        else $error("lock pin high while unlocked");
    a_ref_select: assert property (rst_n |=> ref_use_clk == $past(ref_sel))
        else $error("reference source not following select");
    a_reset_pins: assert property (
        $rose(rst_n) |-> sel_vec == '0)
        else $error("register control active after reset");

endmodule // pin_register_config_select

// ===== bench/lock_model.sv
// Model of the analog lock detector that feeds the lock input
`timescale 1ns/100ps
module lock_model (
    // Clock and request
    input  wire logic clk_sys,
    input  wire logic want_lock,
    // Detector output
    output logic      pll_locked
);
    logic [3:0] settle_r;                        // Cycles spent settling toward lock
    // A real loop takes a while to lock, so lock rises only after nine cycles
    always_ff @(posedge clk_sys) begin
        settle_r   <= want_lock ? ((settle_r == 4'h8) ? settle_r : settle_r + 4'h1) : 4'h0;
        pll_locked <= want_lock && (settle_r == 4'h8);
    end
endmodule // lock_model

// ===== bench/pin_register_config_select_tb.sv
// Testbench for the pin/register configuration selector
`timescale 1ns/100ps
module pin_register_config_select_tb;
    import cfg_sel_pkg::*;
    logic clk_sys, rst_n, cfg_wr_en, init_clk_cmd, ref_sel, want_lock, pll_locked;
    logic ref_use_clk, div_sync, lock;
    logic [NUM_GRP-1:0] cfg_wr_mask;
    reg_image_t cfg_wr_data, cfg_rd_data, img, dflt;
    pin_pair_t pll_preset_pins, bank_a_pins, bank_b_pins, bank_c_pins, bank_d_pins;
    logic [31:0] ref_freq_khz, fpfd_khz, fvco_khz;
    pll_cfg_t pll_eff;
    bank_cfg_t [NUM_BANK-1:0] bank_eff;
    logic [NUM_BANK-1:0] bank_tick;
    int errors, checks, cycles, n;
    pin_register_config_select DUT (.clk_sys(clk_sys), .rst_n(rst_n), .cfg_wr_en(cfg_wr_en),
        .cfg_wr_mask(cfg_wr_mask), .cfg_wr_data(cfg_wr_data), .init_clk_cmd(init_clk_cmd),
        .pll_preset_pins(pll_preset_pins), .bank_a_pins(bank_a_pins),
        .bank_b_pins(bank_b_pins), .bank_c_pins(bank_c_pins), .bank_d_pins(bank_d_pins),
        .ref_sel(ref_sel), .ref_freq_khz(ref_freq_khz), .pll_locked(pll_locked),
        .cfg_rd_data(cfg_rd_data), .ref_use_clk(ref_use_clk), .pll_eff(pll_eff),
        .fpfd_khz(fpfd_khz), .fvco_khz(fvco_khz), .bank_eff(bank_eff),
        .bank_tick(bank_tick), .div_sync(div_sync), .lock(lock));
    lock_model partner (.clk_sys(clk_sys), .want_lock(want_lock), .pll_locked(pll_locked));
    ////////////////////////////////////////////////////////////////////////////////
    // Clock, and a cycle ceiling that cuts a hang short
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            wrap_up();
        end
    end
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge clk_sys);
    endtask
    // One register write, held for exactly one edge
    task automatic wr(input logic [NUM_GRP-1:0] m, input reg_image_t d);
        @(posedge clk_sys);
        cfg_wr_en   <= 1'b1;
        cfg_wr_mask <= m;
        cfg_wr_data <= d;
        @(posedge clk_sys);
        cfg_wr_en   <= 1'b0;
        cyc(3);
        @(negedge clk_sys);
    endtask
    task automatic reset_and_defaults(input int pre);
        @(posedge clk_sys);
        rst_n <= 1'b0;
        cyc(6);
        rst_n <= 1'b1;
        n = 0;
        repeat (30) @(negedge clk_sys) n += int'(div_sync);
        check(64'(cfg_rd_data), 64'(dflt));
        check(64'(n), 64'h1);
        check(64'(pll_eff), 64'(PRESET_TAB[pre].cfg));
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_presets();
        @(posedge clk_sys);
        pll_preset_pins <= '{LVL_HIGH, LVL_HIGH};
        cyc(3);
        @(negedge clk_sys);
        check(64'(pll_eff), 64'(pll_cfg_t'{6'h01, 1'b1, 9'h020}));
        check(64'(fvco_khz), 64'd2488320);
        @(posedge clk_sys);
        pll_preset_pins <= '{LVL_HIGH, LVL_OPEN};
        ref_sel         <= 1'b1;
        cyc(3);
        @(negedge clk_sys);
        check(64'(fvco_khz), 64'd2457600);
        check(64'(ref_use_clk), 64'h1);
        @(posedge clk_sys);
        ref_sel <= 1'b0;
        cyc(3);
        @(negedge clk_sys);
        check(64'(fvco_khz), 64'd2457600);
        check(64'(ref_use_clk), 64'h0);
        // Both pins open must decode as middle/middle, 125 MHz in
        @(posedge clk_sys);
        pll_preset_pins <= '{LVL_OPEN, LVL_OPEN};
        cyc(3);
        @(negedge clk_sys);
        check(64'(fpfd_khz), 64'd125000);
        check(64'(fvco_khz), 64'd2500000);
    endtask
    task automatic t_reg_pll();
        img = dflt;
        img.ctl_sel.pll_group_ctl_sel = 1'b1;
        img.pll = '{6'h01, 1'b1, 9'h032};
        @(posedge clk_sys);
        ref_freq_khz <= 32'd25000;
        wr(5'h01, img);
        check(64'(pll_eff), 64'(img.pll));
        check(64'(fpfd_khz), 64'd50000);
        check(64'(fvco_khz), 64'd2500000);
        @(posedge clk_sys);
        pll_preset_pins <= '{LVL_LOW, LVL_HIGH};
        bank_b_pins     <= '{LVL_MID, LVL_LOW};
        bank_d_pins     <= '{LVL_HIGH, LVL_HIGH};
        cyc(3);
        @(negedge clk_sys);
        check(64'(pll_eff), 64'(img.pll));
        check(64'(bank_eff[1]), 64'(bank_cfg_t'{8'h05, OT_LVPECL}));
        check(64'(bank_eff[3]), 64'(bank_cfg_t'{8'h19, OT_PDOWN}));
        // A powered-down bank must stay silent
        n = 0;
        repeat (30) @(negedge clk_sys) n += int'(bank_tick[3]);
        check(64'(n), 64'h0);
    endtask
    task automatic t_bank_sync();
        img.ctl_sel.bank_a_ctl_sel = 1'b1;
        img.bank[0] = '{8'h08, OT_LVPECL};
        wr(5'h02, img);
        check(64'(bank_eff[0].otype), 64'(OT_LVPECL));
        check(64'(bank_eff[0].div == 8'h08), 64'h0);
        @(posedge clk_sys);
        init_clk_cmd <= 1'b1;
        @(posedge clk_sys);
        init_clk_cmd <= 1'b0;
        n = 0;
        while (div_sync !== 1'b1 && n < 6) @(negedge clk_sys) n++;
        check(64'(bank_eff[0].div), 64'h08);
        n = 0;
        repeat (80) @(negedge clk_sys) n += int'(bank_tick[0]);
        check(64'(n), 64'd10);
    endtask
    task automatic t_lock();
        @(posedge clk_sys);
        want_lock <= 1'b1;
        cyc(14);
        @(negedge clk_sys);
        check(64'(lock), 64'h1);
        @(posedge clk_sys);
        want_lock <= 1'b0;
        cyc(3);
        @(negedge clk_sys);
        check(64'(lock), 64'h0);
    endtask
    task automatic wrap_up();
        if (errors == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence: strap pins start low, as a board with pull-downs would leave them
    initial begin
        {rst_n, cfg_wr_en, init_clk_cmd, ref_sel, want_lock} = '0;
        {cfg_wr_mask, cfg_wr_data, ref_freq_khz} = '0;
        {pll_preset_pins, bank_a_pins, bank_b_pins, bank_c_pins, bank_d_pins} = '0;
        dflt = '{CTL_SEL_RST, PLL_CFG_RST, {NUM_BANK{BANK_CFG_RST}}};
        @(posedge clk_sys);
        reset_and_defaults(0);
        t_presets();
        t_reg_pll();
        t_bank_sync();
        t_lock();
        // Pins were left at low/high, so preset entry 2 applies after reset
        reset_and_defaults(2);
        wrap_up();
    end
endmodule // pin_register_config_select_tb
